// File: logic/tsas_scan_seq.v
// touch screen / port measurement conversion sequencer
// assumes a synchronous register port, analog pins asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
`include "tsas_consts.vh"

// Notes on behaviour
// - pen irq low on touch; host control write picks the single function to convert
// - single y request releases pen irq, starts clock, turns on y drivers
// - after stabilization delay power adc, convert, repeat until averaging done
// - result stored in its data register before completion is signalled
// - on completion power adc down, pull ready low, then stop clock
// - touch coordinate takes 2.125 us + stabilization + per average bits + 4.4 us
// - first temperature reading biases diode at low 20 uA current
// - second temperature reading uses 82 times bias, stored separately
// - battery a divided by four, battery b divided by two
// - battery divider enabled only while that input is sampled
// - port measurement takes 2.625 us + reference delay + per average term
// - reference powered on demand when selected; delay included in timing
// - auxiliary inputs follow battery sequence with no divider
// - results right-justified in 16-bit word, upper bits zero
module tsas_scan_seq
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [3:0]  regAddr,
  input  wire [15:0] regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRdData,
  input  wire        penDetect,
  input  wire        convClk,
  input  wire [11:0] adcSample,
  output reg         penTouchIrqN,
  output reg         resultReadyN,
  output reg         irq,
  output reg         oscRun,
  output reg         adcPowerUp,
  output reg  [3:0]  adcChan,
  output reg  [3:0]  panelDrv,
  output reg         tempBiasLow,
  output reg         tempBiasHigh,
  output reg         batDivA,
  output reg         batDivB,
  output reg         refPowerUp,
  output reg         busy
);
  // ****************************************************************
  // timing counts and states
  // ****************************************************************
  localparam integer TOUCH_OVH_I = `TSAS_CYC(`TSAS_T_TOUCH_OVH_NS);
  localparam integer PORT_OVH_I  = `TSAS_CYC(`TSAS_T_PORT_OVH_NS);
  localparam integer TAIL_CYC_I  = `TSAS_CYC(`TSAS_T_CONV_TAIL_NS);
  localparam [15:0]  TOUCH_OVH   = TOUCH_OVH_I[15:0];
  localparam [15:0]  PORT_OVH    = PORT_OVH_I[15:0];
  localparam [15:0]  TAIL_CYC    = TAIL_CYC_I[15:0];

  localparam [6:0] S_IDLE   = 7'h01;
  localparam [6:0] S_START  = 7'h02;
  localparam [6:0] S_OVH    = 7'h04;
  localparam [6:0] S_SETTLE = 7'h08;
  localparam [6:0] S_CONV   = 7'h10;
  localparam [6:0] S_TAIL   = 7'h20;
  localparam [6:0] S_STORE  = 7'h40;

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  wire        penFlag;
  wire        penRise;
  wire        convRise;
  wire [11:0] adcSync;

  tsas_sync_edge #(.W(1)) uPen
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn (penDetect),
    .syncOut (penFlag),
    .riseOut (penRise)
  );

  tsas_sync_edge #(.W(1)) uConvClk
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn (convClk),
    .syncOut (),
    .riseOut (convRise)
  );

  tsas_sync_edge #(.W(12)) uAdc
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn (adcSample),
    .syncOut (adcSync),
    .riseOut ()
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [`TSAS_CTRL_W-1:0] ctrl_r;
  reg [15:0]             pvs_r;
  reg [15:0]             refDly_r;
  reg [2:0]              intStat_r;
  reg [2:0]              intMask_r;
  reg [15:0]             resultMem [0:`TSAS_NUM_RESULTS-1];
  reg [6:0]              state_r;
  reg [3:0]              func_r;
  reg [1:0]              step_r;
  reg [15:0]             cnt_r;
  reg [4:0]              avgCnt_r;
  reg [15:0]             acc_r;
  reg [2:0]              intSet_r;
  reg                    stopClk_r;
  integer                i;

  wire       cmdWr    = regWr && (regAddr == `TSAS_REG_CTRL);
  wire [3:0] cmdFunc  = regWrData[`TSAS_CTRL_FUNC];
  wire [1:0] resCode  = ctrl_r[`TSAS_CTRL_RES];
  wire [1:0] avgCode  = ctrl_r[`TSAS_CTRL_AVG];
  wire [3:0] nBits    = (resCode == 2'h1) ? 4'h8 : (resCode == 2'h2) ? 4'hA : 4'hC;
  wire [3:0] resShift = 4'hC - nBits;
  wire [4:0] nAvg     = (avgCode == 2'h0) ? 5'h01 : (avgCode == 2'h1) ? 5'h04 :
                        (avgCode == 2'h2) ? 5'h08 : 5'h10;
  wire [2:0] avgShift = (avgCode == 2'h0) ? 3'h0 : (avgCode == 2'h1) ? 3'h2 :
                        (avgCode == 2'h2) ? 3'h3 : 3'h4;
  wire       isTouch  = (func_r >= `TSAS_F_XY) && (func_r <= `TSAS_F_Z);
  wire       cmdTouch = (cmdFunc >= `TSAS_F_XY) && (cmdFunc <= `TSAS_F_DRV_Z);
  wire       cmdDrv   = (cmdFunc >= `TSAS_F_DRV_X) && (cmdFunc <= `TSAS_F_DRV_Z);
  wire       cmdValid = (cmdFunc != `TSAS_F_NONE) && (cmdFunc <= `TSAS_F_TEMP_H);
  wire       isBat    = (func_r == `TSAS_F_BAT_A) || (func_r == `TSAS_F_BAT_B);
  wire [15:0] sampleR = {4'h0, adcSync >> resShift};
  wire [15:0] accNxt  = acc_r + sampleR;

  // ****************************************************************
  // sequence tables
  // ****************************************************************
  function [3:0] chanOf;
    input [3:0] f;
    input [1:0] s;
    begin
      case (f)
        `TSAS_F_XY:     chanOf = (s == 2'h0) ? `TSAS_CH_Y : `TSAS_CH_X;
        `TSAS_F_XYZ:    chanOf = (s == 2'h0) ? `TSAS_CH_Y : (s == 2'h1) ? `TSAS_CH_X :
                                 (s == 2'h2) ? `TSAS_CH_PRS_A : `TSAS_CH_PRS_B;
        `TSAS_F_X:      chanOf = `TSAS_CH_X;
        `TSAS_F_Y:      chanOf = `TSAS_CH_Y;
        `TSAS_F_Z:      chanOf = (s == 2'h0) ? `TSAS_CH_PRS_A : `TSAS_CH_PRS_B;
        `TSAS_F_BAT_A:  chanOf = `TSAS_CH_BAT_A;
        `TSAS_F_BAT_B:  chanOf = `TSAS_CH_BAT_B;
        `TSAS_F_AUX_A:  chanOf = `TSAS_CH_AUX_A;
        `TSAS_F_AUX_B:  chanOf = `TSAS_CH_AUX_B;
        `TSAS_F_TEMP_L: chanOf = `TSAS_CH_TMP_L;
        default:        chanOf = `TSAS_CH_TMP_H;
      endcase
    end
  endfunction

  // drivers {x+, x-, y+, y-} for a touch channel
  function [3:0] drvOf;
    input [3:0] c;
    begin
      case (c)
        `TSAS_CH_X:  drvOf = 4'hC;
        `TSAS_CH_Y:  drvOf = 4'h3;
        `TSAS_CH_PRS_A: drvOf = 4'h6;
        `TSAS_CH_PRS_B: drvOf = 4'h6;
        default:     drvOf = 4'h0;
      endcase
    end
  endfunction

  wire [1:0] lastStep = (func_r == `TSAS_F_XY) ? 2'h1 : (func_r == `TSAS_F_XYZ) ? 2'h3 :
                        (func_r == `TSAS_F_Z) ? 2'h1 : 2'h0;
  wire [3:0] curChan  = chanOf(func_r, step_r);
  wire       lastAvg  = (state_r == S_TAIL) && (cnt_r <= 16'h0001) && (avgCnt_r == nAvg - 5'h01);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r      <= S_IDLE;
      func_r       <= `TSAS_F_NONE;
      step_r       <= 2'h0;
      cnt_r        <= 16'h0000;
      avgCnt_r     <= 5'h00;
      acc_r        <= 16'h0000;
      intSet_r     <= 3'h0;
      stopClk_r    <= 1'b0;
      penTouchIrqN <= 1'b1;
      resultReadyN <= 1'b1;
      oscRun       <= 1'b0;
      adcPowerUp   <= 1'b0;
      adcChan      <= 4'h0;
      panelDrv     <= 4'h0;
      tempBiasLow  <= 1'b0;
      tempBiasHigh <= 1'b0;
      batDivA      <= 1'b0;
      batDivB      <= 1'b0;
      refPowerUp   <= 1'b0;
      busy         <= 1'b0;
    end
    else
    begin
      intSet_r <= {2'h0, penRise};
      if (stopClk_r)
      begin
        oscRun    <= 1'b0;
        stopClk_r <= 1'b0;
      end
      if (regRd && (regAddr >= `TSAS_REG_RES_BASE))
        resultReadyN <= 1'b1;
      case (state_r)
        S_IDLE:
        begin
          busy         <= 1'b0;
          penTouchIrqN <= ~penFlag;
          if (cmdWr && cmdValid)
          begin
            resultReadyN <= 1'b1;
            func_r       <= cmdFunc;
            step_r       <= 2'h0;
            if (cmdTouch && !penFlag)
              intSet_r[`TSAS_INT_ABORT] <= 1'b1;
            else if (cmdDrv)
              panelDrv <= drvOf(cmdFunc - `TSAS_F_DRV_X);
            else
            begin
              penTouchIrqN <= 1'b1;
              oscRun       <= 1'b1;
              busy         <= 1'b1;
              state_r      <= S_START;
            end
          end
        end
        S_START:
        begin
          adcChan      <= curChan;
          panelDrv     <= drvOf(isTouch ? curChan : 4'hF);
          tempBiasLow  <= (curChan == `TSAS_CH_TMP_L);
          tempBiasHigh <= (curChan == `TSAS_CH_TMP_H);
          refPowerUp   <= !isTouch && ctrl_r[`TSAS_CTRL_REF_DEM];
          cnt_r        <= isTouch ? TOUCH_OVH : PORT_OVH;
          state_r      <= S_OVH;
        end
        S_OVH:
        begin
          cnt_r <= cnt_r - 16'h0001;
          if (cnt_r <= 16'h0001)
          begin
            cnt_r   <= isTouch ? pvs_r : refDly_r;
            state_r <= S_SETTLE;
          end
        end
        S_SETTLE:
        begin
          cnt_r <= cnt_r - 16'h0001;
          if (cnt_r <= 16'h0001)
          begin
            adcPowerUp <= 1'b1;
            cnt_r      <= 16'h0000;
            avgCnt_r   <= 5'h00;
            acc_r      <= 16'h0000;
            batDivA    <= (curChan == `TSAS_CH_BAT_A);
            batDivB    <= (curChan == `TSAS_CH_BAT_B);
            state_r    <= S_CONV;
          end
        end
        S_CONV:
        begin
          if (convRise)
          begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r[3:0] == nBits - 4'h1)
            begin
              batDivA <= 1'b0;
              batDivB <= 1'b0;
              cnt_r   <= TAIL_CYC;
              state_r <= S_TAIL;
            end
          end
        end
        S_TAIL:
        begin
          cnt_r <= cnt_r - 16'h0001;
          if (cnt_r <= 16'h0001)
          begin
            acc_r    <= accNxt;
            avgCnt_r <= avgCnt_r + 5'h01;
            cnt_r    <= 16'h0000;
            if (avgCnt_r == nAvg - 5'h01)
            begin
              adcPowerUp <= 1'b0;
              state_r    <= S_STORE;
            end
            else
            begin
              batDivA <= isBat && (curChan == `TSAS_CH_BAT_A);
              batDivB <= isBat && (curChan == `TSAS_CH_BAT_B);
              state_r <= S_CONV;
            end
          end
        end
        S_STORE:
        begin
          adcPowerUp <= 1'b0;
          if (step_r != lastStep && !(isTouch && !penFlag))
          begin
            step_r  <= step_r + 2'h1;
            state_r <= S_START;
          end
          else
          begin
            panelDrv     <= 4'h0;
            tempBiasLow  <= 1'b0;
            tempBiasHigh <= 1'b0;
            refPowerUp   <= 1'b0;
            stopClk_r    <= 1'b1;
            state_r      <= S_IDLE;
            if (step_r != lastStep)
              intSet_r[`TSAS_INT_ABORT] <= 1'b1;
            else
            begin
              resultReadyN             <= 1'b0;
              intSet_r[`TSAS_INT_DONE] <= 1'b1;
            end
          end
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // result lands one edge before ready falls; slots read zero after reset
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (i = 0; i < `TSAS_NUM_RESULTS; i = i + 1)
        resultMem[i] <= 16'h0000;
    end
    else if (lastAvg)
      resultMem[curChan] <= accNxt >> avgShift;
  end

  // ****************************************************************
  // register port and interrupt
  // ****************************************************************
  wire [3:0] resIdx = regAddr - `TSAS_REG_RES_BASE;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_r    <= `TSAS_CTRL_RST;
      pvs_r     <= `TSAS_PVS_RST;
      refDly_r  <= `TSAS_REF_DLY_RST;
      intStat_r <= 3'h0;
      intMask_r <= 3'h0;
      regRdData <= 16'h0000;
      irq       <= 1'b0;
    end
    else
    begin
      if (regWr && (state_r == S_IDLE))
      begin
        if (regAddr == `TSAS_REG_CTRL)
          ctrl_r <= regWrData[`TSAS_CTRL_W-1:0];
        if (regAddr == `TSAS_REG_PVS)
          pvs_r <= regWrData;
        if (regAddr == `TSAS_REG_REF_DLY)
          refDly_r <= regWrData;
      end
      if (regWr && (regAddr == `TSAS_REG_INT_MASK))
        intMask_r <= regWrData[2:0];
      if (regWr && (regAddr == `TSAS_REG_INT_STAT))
        intStat_r <= (intStat_r & ~regWrData[2:0]) | intSet_r;
      else
        intStat_r <= intStat_r | intSet_r;
      irq <= |(intStat_r & intMask_r);
      regRdData <= 16'h0000;
      if (regRd)
      begin
        case (regAddr)
          `TSAS_REG_CTRL:     regRdData <= {7'h00, ctrl_r};
          `TSAS_REG_STATUS:   regRdData <= {13'h0000, ~resultReadyN, busy, penFlag};
          `TSAS_REG_INT_STAT: regRdData <= {13'h0000, intStat_r};
          `TSAS_REG_INT_MASK: regRdData <= {13'h0000, intMask_r};
          `TSAS_REG_PVS:      regRdData <= pvs_r;
          `TSAS_REG_REF_DLY:  regRdData <= refDly_r;
          default:            regRdData <= resultMem[resIdx];
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/tsas_consts.vh
// constants of the touch scan sequencer: register map, fields, codes, timing
// assumes a 20 MHz system clock and a 4-bit word-indexed register port
`ifndef TSAS_CONSTS_VH
`define TSAS_CONSTS_VH

// ****************************************************************
// timing
// ****************************************************************
`define TSAS_CLK_PERIOD_NS  50
`define TSAS_T_TOUCH_OVH_NS 2125
`define TSAS_T_PORT_OVH_NS  2625
`define TSAS_T_CONV_TAIL_NS 4400
`define TSAS_CYC(ns)        (((ns) + `TSAS_CLK_PERIOD_NS - 1) / `TSAS_CLK_PERIOD_NS)

// ****************************************************************
// register indices
// ****************************************************************
`define TSAS_REG_CTRL      4'h0
`define TSAS_REG_STATUS    4'h1
`define TSAS_REG_INT_STAT  4'h2
`define TSAS_REG_INT_MASK  4'h3
`define TSAS_REG_PVS       4'h4
`define TSAS_REG_REF_DLY   4'h5
`define TSAS_REG_RES_BASE  4'h6
`define TSAS_NUM_RESULTS   10

// ****************************************************************
// fields and reset values
// ****************************************************************
`define TSAS_CTRL_FUNC     3:0
`define TSAS_CTRL_RES      5:4
`define TSAS_CTRL_AVG      7:6
`define TSAS_CTRL_REF_DEM  8
`define TSAS_CTRL_W        9
`define TSAS_CTRL_RST      9'h000
`define TSAS_PVS_RST       16'h0064
`define TSAS_REF_DLY_RST   16'h0064
`define TSAS_INT_PEN       0
`define TSAS_INT_DONE      1
`define TSAS_INT_ABORT     2

// ****************************************************************
// function codes written to the control field
// ****************************************************************
`define TSAS_F_NONE   4'h0
`define TSAS_F_XY     4'h1
`define TSAS_F_XYZ    4'h2
`define TSAS_F_X      4'h3
`define TSAS_F_Y      4'h4
`define TSAS_F_Z      4'h5
`define TSAS_F_DRV_X  4'h6
`define TSAS_F_DRV_Y  4'h7
`define TSAS_F_DRV_Z  4'h8
`define TSAS_F_BAT_A  4'h9
`define TSAS_F_BAT_B  4'hA
`define TSAS_F_AUX_A  4'hB
`define TSAS_F_AUX_B  4'hC
`define TSAS_F_TEMP_L 4'hD
`define TSAS_F_TEMP_H 4'hE

// ****************************************************************
// channel codes, also result slot numbers
// ****************************************************************
`define TSAS_CH_X     4'h0
`define TSAS_CH_Y     4'h1
`define TSAS_CH_PRS_A 4'h2
`define TSAS_CH_PRS_B 4'h3
`define TSAS_CH_BAT_A 4'h4
`define TSAS_CH_BAT_B 4'h5
`define TSAS_CH_AUX_A 4'h6
`define TSAS_CH_AUX_B 4'h7
`define TSAS_CH_TMP_L 4'h8
`define TSAS_CH_TMP_H 4'h9

`endif

// File: logic/tsas_sync_edge.v
// two-flop synchroniser with rising-edge detect behind it
// assumes inputs asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module tsas_sync_edge
#(
  parameter W = 1
)
(
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut,
  output wire [W-1:0] riseOut
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  reg [W-1:0] prev_r;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
      prev_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= asyncIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign syncOut = sync_r;
  assign riseOut = sync_r & ~prev_r;
endmodule
`default_nettype wire

// File: verification/tsas_scan_seq_chk.sv
// checker for the scan sequencer outputs
// assumes binding into tsas_scan_seq, one clock domain
`timescale 1ns/100ps
`default_nettype none
module tsas_scan_seq_chk
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  input wire logic        penTouchIrqN,
  input wire logic        resultReadyN,
  input wire logic        oscRun,
  input wire logic        adcPowerUp,
  input wire logic [3:0]  adcChan,
  input wire logic [3:0]  panelDrv,
  input wire logic        tempBiasLow,
  input wire logic        tempBiasHigh,
  input wire logic        batDivA,
  input wire logic        batDivB,
  input wire logic        refPowerUp,
  input wire logic        busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************
  // sequences
  // ****************
  sequence adcWasOff;
    !adcPowerUp && !$past(adcPowerUp);
  endsequence
  sequence clkStops;
    oscRun ##1 !oscRun;
  endsequence
  startRelease_a: assert property ($rose(busy) |-> oscRun && penTouchIrqN)
    else $error("start without clock or pen release");
  yDrive_a: assert property (adcPowerUp && adcChan == 4'h1 |-> panelDrv == 4'h3)
    else $error("y conversion without y drivers");
  xDrive_a: assert property (adcPowerUp && adcChan == 4'h0 |-> panelDrv == 4'hC)
    else $error("x conversion without x drivers");
  adcPower_a: assert property (adcPowerUp |-> oscRun && busy)
    else $error("converter powered outside a sequence");
  doneOrder_a: assert property ($fell(resultReadyN) |-> adcWasOff ##0 clkStops)
    else $error("completion order wrong");
  divA_a: assert property (batDivA |-> adcPowerUp && adcChan == 4'h4 && !batDivB)
    else $error("divider a on outside its sampling");
  divB_a: assert property (batDivB |-> adcPowerUp && adcChan == 4'h5 && !batDivA)
    else $error("divider b on outside its sampling");
  biasHigh_a: assert property (tempBiasHigh |-> adcChan == 4'h9 && !tempBiasLow)
    else $error("high bias on wrong channel");
  biasLow_a: assert property (tempBiasLow |-> adcChan == 4'h8)
    else $error("low bias on wrong channel");
  refDemand_a: assert property (refPowerUp |-> busy && adcChan >= 4'h4)
    else $error("reference on outside port measurement");
  readIdle_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data outside read answer");
endmodule
bind tsas_scan_seq tsas_scan_seq_chk tsas_scan_seq_chk_i (.clk(clk), .sys_rst(sys_rst),
  .regRd(regRd), .regRdData(regRdData), .penTouchIrqN(penTouchIrqN),
  .resultReadyN(resultReadyN), .oscRun(oscRun), .adcPowerUp(adcPowerUp), .adcChan(adcChan),
  .panelDrv(panelDrv), .tempBiasLow(tempBiasLow), .tempBiasHigh(tempBiasHigh),
  .batDivA(batDivA), .batDivB(batDivB), .refPowerUp(refPowerUp), .busy(busy));
`default_nettype wire

// File: verification/tsas_panel_model.sv
// panel and converter model: conversion clock and sample codes
// assumes the sequencer drives channel, drivers and power pins
`timescale 1ns/100ps
`default_nettype none
module tsas_panel_model
(
  input  wire logic        oscRun,
  input  wire logic        adcPowerUp,
  input  wire logic [3:0]  adcChan,
  input  wire logic [3:0]  panelDrv,
  input  wire logic [7:0]  tag,
  output var  logic        convClk,
  output var  logic [11:0] adcSample
);
  logic [3:0] wantDrv;
  always_comb
  begin
    case (adcChan)
      4'h0: wantDrv = 4'hC;
      4'h1: wantDrv = 4'h3;
      4'h2, 4'h3: wantDrv = 4'h6;
      default: wantDrv = panelDrv;
    endcase
    // wrong drivers or converter off give a corrupted code
    if (adcPowerUp && panelDrv == wantDrv)
      adcSample = {adcChan, tag};
    else
      adcSample = ~{adcChan, tag};
  end
  // clock stands still while the oscillator is off
  initial
  begin
    convClk = 1'b0;
    #7;
    forever #200 convClk = oscRun ? ~convClk : 1'b0;
  end
endmodule
`default_nettype wire

// File: verification/tsas_scan_seq_tb.sv
// self-checking bench for the scan sequencer
// assumes the panel model on the analog side, bench as host
`timescale 1ns/100ps
`default_nettype none
module tsas_scan_seq_tb;
  logic        clk;
  logic        sys_rst;
  logic [3:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic        penDetect;
  logic [7:0]  tag;
  wire  logic  convClk;
  wire  logic [11:0] adcSample;
  wire  logic [15:0] regRdData;
  wire  logic  penTouchIrqN, resultReadyN, irq, oscRun, adcPowerUp, busy;
  wire  logic  tempBiasLow, tempBiasHigh, batDivA, batDivB, refPowerUp;
  wire  logic [3:0] adcChan;
  wire  logic [3:0] panelDrv;
  int          n_errors;
  int          total_checks;
  int          cyc;
  logic [15:0] expRes [0:9];

  tsas_scan_seq tsas_scan_seq_i (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .penDetect(penDetect), .convClk(convClk), .adcSample(adcSample),
    .penTouchIrqN(penTouchIrqN), .resultReadyN(resultReadyN), .irq(irq), .oscRun(oscRun),
    .adcPowerUp(adcPowerUp), .adcChan(adcChan), .panelDrv(panelDrv),
    .tempBiasLow(tempBiasLow), .tempBiasHigh(tempBiasHigh), .batDivA(batDivA),
    .batDivB(batDivB), .refPowerUp(refPowerUp), .busy(busy));
  tsas_panel_model tsas_panel_model_i (.oscRun(oscRun), .adcPowerUp(adcPowerUp),
    .adcChan(adcChan), .panelDrv(panelDrv), .tag(tag), .convClk(convClk),
    .adcSample(adcSample));

  // ****************
  // helpers
  // ****************
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one sequence: start, time it, read every slot, clear
  task automatic seq(input logic [15:0] ctrl, input int lo, input logic [9:0] slots);
    int n;
    logic [15:0] d;
    tag <= tag + 8'h11;
    wr(4'h0, ctrl);
    n = 0;
    while (resultReadyN !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("ready fall", {15'h0, resultReadyN}, 16'h0000);
    if (lo > 0)
      check("cycles", {15'h0, n >= lo && n <= lo + 16}, 16'h0001);
    repeat (2) @(posedge clk);
    #1;
    check("irq", {15'h0, irq}, 16'h0001);
    for (int i = 0; i < 10; i++)
    begin
      if (slots[i])
        expRes[i] = {4'h0, i[3:0], tag};
      rd(4'h6 + i[3:0], d);
      check("result", d, expRes[i]);
    end
    check("ready release", {15'h0, resultReadyN}, 16'h0001);
    wr(4'h2, 16'h0007);
    @(posedge clk);
    #1;
    check("irq clear", {15'h0, irq}, 16'h0000);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    logic [15:0] d;
    check("pen irq", {15'h0, penTouchIrqN}, 16'h0001);
    rd(4'h4, d);
    check("settle", d, 16'h0064);
    rd(4'h5, d);
    check("ref delay", d, 16'h0064);
  endtask
  task automatic t_abort;
    logic [15:0] d;
    wr(4'h0, 16'h0004);
    repeat (20) @(posedge clk);
    #1;
    check("busy", {15'h0, busy}, 16'h0000);
    rd(4'h2, d);
    check("abort flag", {15'h0, d[2]}, 16'h0001);
    rd(4'h7, d);
    check("y slot", d, 16'h0000);
    wr(4'h2, 16'h0007);
  endtask
  task automatic t_pen;
    logic [15:0] d;
    @(posedge clk);
    penDetect <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check("pen irq", {15'h0, penTouchIrqN}, 16'h0000);
    rd(4'h2, d);
    check("pen flag", {15'h0, d[0]}, 16'h0001);
    wr(4'h3, 16'h0002);
    wr(4'h2, 16'h0007);
    wr(4'h4, 16'h000A);
    wr(4'h5, 16'h000C);
  endtask
  task automatic t_touch;
    logic [3:0] fn [5] = '{4'h3, 4'h4, 4'h1, 4'h2, 4'h5};
    logic [9:0] sl [5] = '{10'h001, 10'h002, 10'h003, 10'h00F, 10'h00C};
    for (int i = 0; i < 5; i++)
      seq({12'h000, fn[i]}, (i < 2) ? 229 : 0, sl[i]);
    seq(16'h0044, 0, 10'h002);
  endtask
  task automatic t_ports;
    for (int f = 9; f < 15; f++)
      seq(16'h0100 | f[15:0], 241, 10'h001 << (f - 5));
  endtask
  task automatic t_drivers;
    wr(4'h0, 16'h0006);
    repeat (5) @(posedge clk);
    #1;
    check("drivers", {12'h000, panelDrv}, 16'h000C);
  endtask

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    penDetect = 1'b0;
    tag = 8'h00;
    foreach (expRes[i])
      expRes[i] = 16'h0000;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_abort;
    t_pen;
    t_touch;
    t_ports;
    t_drivers;
    wrap_up;
  end
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      wrap_up;
    end
  end
endmodule
`default_nettype wire
